//--- verilog/dasr_pkg.sv
// constants and carrier types of the dual converter serial readout
package dasr_pkg;

	// ****************************************************************
	// frame timing in serial clock edges, result width and fifo depth
	// ****************************************************************
	localparam int unsigned FRAME_EDGES = 16;
	localparam int unsigned EXT_EDGES   = 32;
	localparam logic [5:0]  WORD_FALLS  = 6'h10;
	localparam logic [5:0]  LAST_RISE   = 6'h20;
	localparam logic [5:0]  TRACK_FALLS = 6'h0D;
	localparam logic [5:0]  PD_MIN      = 6'h02;
	localparam logic [5:0]  PD_MAX      = 6'h0A;
	localparam int unsigned RESULT_W    = 12;
	localparam int unsigned FIFO_DEPTH  = 16;

	// ****************************************************************
	// register map, byte addresses
	// ****************************************************************
	localparam logic [3:0] OFS_CTRL   = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_LAST_A = 4'h8;
	localparam logic [3:0] OFS_LAST_B = 4'hC;

	localparam int unsigned CTRL_RANGE   = 0;
	localparam int unsigned CTRL_CHANNEL = 1;
	localparam logic [1:0]  CTRL_RESET   = 2'h0;

	localparam int unsigned ST_ACTIVE = 0;
	localparam int unsigned ST_HOLD   = 1;
	localparam int unsigned ST_PWR_LO = 2;
	localparam int unsigned ST_PWR_HI = 4;
	localparam int unsigned ST_EMPTY  = 5;
	localparam int unsigned ST_FALL_LO = 8;
	localparam int unsigned ST_FALL_HI = 13;
	localparam int unsigned ST_LVL_LO = 16;
	localparam int unsigned ST_LVL_HI = 20;

	// ****************************************************************
	// states
	// ****************************************************************
	typedef enum logic [2:0]
	{
		PWR_NORMAL  = 3'b001,
		PWR_PARTIAL = 3'b010,
		PWR_FULL    = 3'b100
	} dasr_pwr_t;

	typedef enum logic [2:0]
	{
		FRM_IDLE  = 3'b001,
		FRM_SHIFT = 3'b010,
		FRM_DONE  = 3'b100
	} dasr_frm_t;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed
	{
		logic                zero;
		logic                range;
		logic                channel_flag;
		logic                conv_id;
		logic [RESULT_W-1:0] result;
	} dasr_word_t;

	typedef struct packed
	{
		logic [RESULT_W-1:0] res_a;
		logic [RESULT_W-1:0] res_b;
	} dasr_pair_t;

endpackage : dasr_pkg

//--- verilog/dasr_top.sv
// serial conversion and readout logic with result fifo and register slave
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ns

// ********************************************************************
// result fifo
// ********************************************************************
module dasr_fifo
#(
	parameter int unsigned WIDTH = 24,
	parameter int unsigned DEPTH = 16
)
(
	input  wire logic             core_clk,
	input  wire logic             reset_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic      [4:0]       level
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      cnt_reg;
	logic [AW:0]      cnt_next;
	logic             ready_reg;
	logic             valid_reg;
	wire              push = in_valid & ready_reg;
	wire              pop  = out_ready & valid_reg;

	assign cnt_next  = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
	assign in_ready  = ready_reg;
	assign out_valid = valid_reg;
	assign out_data  = mem_reg[rd_ptr_reg];
	assign level     = 5'(cnt_reg);

	always_ff @(posedge core_clk)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg    <= '0;
			ready_reg  <= 1'b0;
			valid_reg  <= 1'b0;
		end
		else
		begin
			wr_ptr_reg <= push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
			rd_ptr_reg <= pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
			cnt_reg    <= cnt_next;
			ready_reg  <= cnt_next != FULL_CNT;
			valid_reg  <= cnt_next != '0;
		end
	end
endmodule : dasr_fifo

module dasr_top
#(
	parameter int unsigned FIFO_DEPTH = dasr_pkg::FIFO_DEPTH
)
(
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        sample_valid,
	output logic             sample_ready,
	input  wire logic [23:0] sample_data,
	input  wire logic        frame_sel_n,
	input  wire logic        serial_clk,
	output logic             serial_out_first,
	output logic             serial_out_first_oe,
	output logic             serial_out_second,
	output logic             serial_out_second_oe,
	output logic             hold_active,
	output logic      [2:0]  power_state
);
	// ****************************************************************
	// link synchronisers and edge detection
	// ****************************************************************
	logic cs_meta_reg;
	logic cs_sync_reg;
	logic cs_prev_reg;
	logic ck_meta_reg;
	logic ck_sync_reg;
	logic ck_prev_reg;

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cs_meta_reg <= 1'b1;
			cs_sync_reg <= 1'b1;
			cs_prev_reg <= 1'b1;
			ck_meta_reg <= 1'b0;
			ck_sync_reg <= 1'b0;
			ck_prev_reg <= 1'b0;
		end
		else
		begin
			cs_meta_reg <= frame_sel_n;
			cs_sync_reg <= cs_meta_reg;
			cs_prev_reg <= cs_sync_reg;
			ck_meta_reg <= serial_clk;
			ck_sync_reg <= ck_meta_reg;
			ck_prev_reg <= ck_sync_reg;
		end
	end

	wire cs_fall = cs_prev_reg & ~cs_sync_reg;
	wire cs_rise = ~cs_prev_reg & cs_sync_reg;
	wire ck_fall = ck_prev_reg & ~ck_sync_reg;
	wire ck_rise = ~ck_prev_reg & ck_sync_reg;

	// ****************************************************************
	// state declarations
	// ****************************************************************
	dasr_pkg::dasr_frm_t frm_reg;
	dasr_pkg::dasr_pwr_t pwr_reg;
	dasr_pkg::dasr_pwr_t pwr_next;
	logic [1:0]  ctrl_reg;
	logic        empty_flag_reg;
	logic [5:0]  fall_cnt_reg;
	logic [5:0]  rise_cnt_reg;
	logic [31:0] shift_a_reg;
	logic [31:0] shift_b_reg;
	logic        out_a_reg;
	logic        out_b_reg;
	logic        oe_reg;
	logic        hold_reg;
	logic        wake_reg;
	logic        busy_reg;
	logic [15:0] last_a_reg;
	logic [15:0] last_b_reg;
	logic        wait_reg;
	logic [31:0] rdata_reg;

	// ****************************************************************
	// result fifo in the sample path
	// ****************************************************************
	logic                 fifo_valid;
	logic                 fifo_pop;
	logic [4:0]           fifo_level;
	dasr_pkg::dasr_pair_t pair;

	dasr_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH)) u_fifo
	(
		.core_clk  (core_clk),
		.reset_n   (reset_n),
		.in_valid  (sample_valid),
		.in_ready  (sample_ready),
		.in_data   (sample_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (pair),
		.level     (fifo_level)
	);

	// ****************************************************************
	// frame start decode and word build
	// ****************************************************************
	wire frm_idle   = frm_reg == dasr_pkg::FRM_IDLE;
	wire frm_open   = !frm_idle;
	wire powered    = pwr_reg == dasr_pkg::PWR_NORMAL;
	wire start      = cs_fall & frm_idle;
	wire have_data  = fifo_valid & powered;
	wire no_sample  = start & powered & ~fifo_valid;
	wire [5:0] fall_inc = fall_cnt_reg + 6'h01;
	wire [5:0] rise_inc = rise_cnt_reg + 6'h01;
	wire sh_fall    = ck_fall & (frm_reg == dasr_pkg::FRM_SHIFT);
	wire sh_rise    = ck_rise & (frm_reg == dasr_pkg::FRM_SHIFT);
	wire ext_end    = sh_rise & (rise_inc == dasr_pkg::LAST_RISE);
	wire pd_window  = (fall_cnt_reg >= dasr_pkg::PD_MIN) &
	                  (fall_cnt_reg < dasr_pkg::PD_MAX);
	wire wake_done  = fall_cnt_reg >= dasr_pkg::PD_MAX;
	wire abort      = cs_rise & frm_open;

	assign fifo_pop = start & have_data;

	dasr_pkg::dasr_word_t word_a;
	dasr_pkg::dasr_word_t word_b;

	assign word_a.zero         = 1'b0;
	assign word_a.range        = ctrl_reg[dasr_pkg::CTRL_RANGE];
	assign word_a.channel_flag = ctrl_reg[dasr_pkg::CTRL_CHANNEL];
	assign word_a.conv_id      = 1'b0;
	assign word_a.result       = have_data ? pair.res_a : '0;
	assign word_b.zero         = 1'b0;
	assign word_b.range        = ctrl_reg[dasr_pkg::CTRL_RANGE];
	assign word_b.channel_flag = ctrl_reg[dasr_pkg::CTRL_CHANNEL];
	assign word_b.conv_id      = 1'b1;
	assign word_b.result       = have_data ? pair.res_b : '0;

	// ****************************************************************
	// frame sequencer
	// ****************************************************************
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			frm_reg <= dasr_pkg::FRM_IDLE;
		else
		begin
			case (frm_reg)
				dasr_pkg::FRM_IDLE:
					frm_reg <= start ? dasr_pkg::FRM_SHIFT : frm_reg;
				dasr_pkg::FRM_SHIFT:
					if (cs_rise)
						frm_reg <= dasr_pkg::FRM_IDLE;
					else if (ext_end)
						frm_reg <= dasr_pkg::FRM_DONE;
				dasr_pkg::FRM_DONE:
					frm_reg <= cs_rise ? dasr_pkg::FRM_IDLE : frm_reg;
				default:
					frm_reg <= dasr_pkg::FRM_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// edge counters and shifters, paced by the serial clock
	// ****************************************************************
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			fall_cnt_reg <= '0;
			rise_cnt_reg <= '0;
		end
		else if (start)
		begin
			fall_cnt_reg <= '0;
			rise_cnt_reg <= '0;
		end
		else
		begin
			fall_cnt_reg <= sh_fall ? fall_inc : fall_cnt_reg;
			rise_cnt_reg <= sh_rise ? rise_inc : rise_cnt_reg;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			shift_a_reg <= '0;
			shift_b_reg <= '0;
			out_a_reg   <= 1'b0;
			out_b_reg   <= 1'b0;
		end
		else if (start)
		begin
			shift_a_reg <= {word_a, word_b};
			shift_b_reg <= {word_b, word_a};
			out_a_reg   <= word_a.zero;
			out_b_reg   <= word_b.zero;
		end
		else if (sh_fall)
		begin
			shift_a_reg <= {shift_a_reg[30:0], 1'b0};
			shift_b_reg <= {shift_b_reg[30:0], 1'b0};
			out_a_reg   <= shift_a_reg[30];
			out_b_reg   <= shift_b_reg[30];
		end
	end

	// ****************************************************************
	// output enable, conversion busy, track and hold
	// ****************************************************************
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			oe_reg <= 1'b0;
		else if (start)
			oe_reg <= 1'b1;
		else if (abort | ext_end)
			oe_reg <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			busy_reg <= 1'b0;
		else if (start)
			busy_reg <= 1'b1;
		else if (abort | (sh_fall & (fall_inc == dasr_pkg::WORD_FALLS)))
			busy_reg <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			hold_reg <= 1'b0;
			wake_reg <= 1'b0;
		end
		else if (start)
		begin
			hold_reg <= 1'b1;
			wake_reg <= !powered;
		end
		else if (abort)
		begin
			hold_reg <= pwr_next != dasr_pkg::PWR_NORMAL;
			wake_reg <= 1'b0;
		end
		else if (wake_reg & (sh_fall | sh_rise))
		begin
			hold_reg <= 1'b0;
			wake_reg <= 1'b0;
		end
		else if (sh_rise & (fall_cnt_reg >= dasr_pkg::TRACK_FALLS))
			hold_reg <= 1'b0;
	end

	// ****************************************************************
	// power mode
	// ****************************************************************
	always_comb
	begin
		pwr_next = pwr_reg;
		if (abort & pd_window)
		begin
			case (pwr_reg)
				dasr_pkg::PWR_NORMAL:  pwr_next = dasr_pkg::PWR_PARTIAL;
				dasr_pkg::PWR_PARTIAL: pwr_next = dasr_pkg::PWR_FULL;
				dasr_pkg::PWR_FULL:    pwr_next = dasr_pkg::PWR_FULL;
				default:               pwr_next = dasr_pkg::PWR_NORMAL;
			endcase
		end
		else if (abort & wake_done)
			pwr_next = dasr_pkg::PWR_NORMAL;
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			pwr_reg <= dasr_pkg::PWR_NORMAL;
		else
			pwr_reg <= pwr_next;
	end

	// ****************************************************************
	// register slave
	// ****************************************************************
	wire        req      = avs_read | avs_write;
	wire        wr_take  = avs_write & ~wait_reg;
	wire        sel_ctrl = avs_address == dasr_pkg::OFS_CTRL;
	wire        sel_stat = avs_address == dasr_pkg::OFS_STATUS;
	wire        sel_la   = avs_address == dasr_pkg::OFS_LAST_A;
	wire        sel_lb   = avs_address == dasr_pkg::OFS_LAST_B;
	wire        clr_empty = wr_take & sel_stat & avs_byteenable[0] &
	                        avs_writedata[dasr_pkg::ST_EMPTY];
	logic [31:0] status_word;
	wire [31:0] rd_mux =
		sel_ctrl ? {30'h0, ctrl_reg} :
		sel_stat ? status_word :
		sel_la   ? {16'h0, last_a_reg} :
		sel_lb   ? {16'h0, last_b_reg} : 32'h0;

	always_comb
	begin
		status_word = '0;
		status_word[dasr_pkg::ST_ACTIVE] = busy_reg;
		status_word[dasr_pkg::ST_HOLD]   = hold_reg;
		status_word[dasr_pkg::ST_PWR_HI:dasr_pkg::ST_PWR_LO] = pwr_reg;
		status_word[dasr_pkg::ST_EMPTY]  = empty_flag_reg;
		status_word[dasr_pkg::ST_FALL_HI:dasr_pkg::ST_FALL_LO] = fall_cnt_reg;
		status_word[dasr_pkg::ST_LVL_HI:dasr_pkg::ST_LVL_LO] = fifo_level;
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wait_reg  <= 1'b1;
			rdata_reg <= '0;
		end
		else
		begin
			wait_reg  <= ~(req & wait_reg);
			rdata_reg <= (avs_read & wait_reg) ? rd_mux : rdata_reg;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			ctrl_reg <= dasr_pkg::CTRL_RESET;
		else if (wr_take & sel_ctrl & avs_byteenable[0])
			ctrl_reg <= avs_writedata[1:0];
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			empty_flag_reg <= 1'b0;
		else
			empty_flag_reg <= no_sample | (empty_flag_reg & ~clr_empty);
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			last_a_reg <= '0;
			last_b_reg <= '0;
		end
		else if (start)
		begin
			last_a_reg <= word_a;
			last_b_reg <= word_b;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign avs_readdata         = rdata_reg;
	assign avs_waitrequest      = wait_reg;
	assign serial_out_first     = out_a_reg;
	assign serial_out_second    = out_b_reg;
	assign serial_out_first_oe  = oe_reg;
	assign serial_out_second_oe = oe_reg;
	assign hold_active          = hold_reg;
	assign power_state          = pwr_reg;
endmodule : dasr_top

//--- verification/dasr_host_model.sv
// host serial port model: frame select, serial clock, bit capture
`timescale 1ns/1ns
module dasr_host_model
(
	output logic      frame_sel_n,
	output logic      serial_clk,
	input  wire logic serial_out_first,
	input  wire logic serial_out_first_oe,
	input  wire logic serial_out_second,
	input  wire logic serial_out_second_oe
);
	logic        line_first;
	logic        line_second;
	logic [31:0] cap_first;
	logic [31:0] cap_second;

	// a floating line shows the inverse of its last value
	assign line_first  = serial_out_first_oe ? serial_out_first
		: ~serial_out_first;
	assign line_second = serial_out_second_oe ? serial_out_second
		: ~serial_out_second;

	initial
	begin
		frame_sel_n = 1'b1;
		serial_clk  = 1'b1;
	end

	// ****************************************************************
	// one frame; clock idles high, bits taken just before each fall
	// ****************************************************************
	task automatic run_frame(input int falls);
		cap_first  = 32'h0000_0000;
		cap_second = 32'h0000_0000;
		#37;
		frame_sel_n = 1'b0;
		#400;
		for (int i = 0; i < falls; i++)
		begin
			// same bit a slow host would take at the rise before
			cap_first  = {cap_first[30:0], line_first};
			cap_second = {cap_second[30:0], line_second};
			serial_clk = 1'b0;
			#400;
			serial_clk = 1'b1;
			#400;
		end
		#400;
		frame_sel_n = 1'b1;
		#800;
	endtask : run_frame
endmodule : dasr_host_model

//--- verification/dasr_monitor.sv
// concurrent assertions on the serial readout top ports
`timescale 1ns/1ns
module dasr_monitor
(
	input wire logic        core_clk,
	input wire logic        reset_n,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        sample_valid,
	input wire logic        sample_ready,
	input wire logic [23:0] sample_data,
	input wire logic        frame_sel_n,
	input wire logic        serial_clk,
	input wire logic        serial_out_first,
	input wire logic        serial_out_first_oe,
	input wire logic        serial_out_second,
	input wire logic        serial_out_second_oe,
	input wire logic        hold_active,
	input wire logic [2:0]  power_state
);
	// ****************************************************************
	// serial clock edges seen at the pins within a frame
	// ****************************************************************
	logic       sclk_prev_reg;
	logic       sclk_fell;
	logic       sclk_rose;
	logic       oe_both;
	logic [5:0] fall_cnt_reg;
	logic [5:0] rise_cnt_reg;
	assign sclk_fell = sclk_prev_reg & ~serial_clk;
	assign sclk_rose = ~sclk_prev_reg & serial_clk;
	assign oe_both   = serial_out_first_oe & serial_out_second_oe;
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sclk_prev_reg <= 1'b1;
			fall_cnt_reg  <= 6'h00;
			rise_cnt_reg  <= 6'h00;
		end
		else
		begin
			sclk_prev_reg <= serial_clk;
			fall_cnt_reg  <= frame_sel_n ? 6'h00
				: fall_cnt_reg + {5'h00, sclk_fell};
			rise_cnt_reg  <= frame_sel_n ? 6'h00
				: rise_cnt_reg + {5'h00, sclk_rose};
		end
	end

	// ****************************************************************
	// properties
	// ****************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	sequence s_opened; ##[2:6] (oe_both && hold_active); endsequence
	sequence s_pd_abort; $rose(frame_sel_n) && power_state == 3'h1
		&& fall_cnt_reg >= 6'h02 && fall_cnt_reg <= 6'h09; endsequence
	property p_wait_ans; (avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest; endproperty
	a_wait_ans: assert property (p_wait_ans) else $error("no bus answer");
	property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
	a_wait_one: assert property (p_wait_one) else $error("wait low too long");
	property p_open; $fell(frame_sel_n) |-> s_opened; endproperty
	a_open: assert property (p_open) else $error("frame start late");
	property p_lead; $rose(serial_out_first_oe)
		|-> !serial_out_first && !serial_out_second; endproperty
	a_lead: assert property (p_lead) else $error("no leading zero");
	property p_float; frame_sel_n [*6]
		|-> !serial_out_first_oe && !serial_out_second_oe; endproperty
	a_float: assert property (p_float) else $error("lines not floated");
	property p_stand; !frame_sel_n && fall_cnt_reg != 6'h00
		&& rise_cnt_reg < 6'h20 |-> oe_both; endproperty
	a_stand: assert property (p_stand) else $error("lines dropped");
	property p_ext; (!frame_sel_n && rise_cnt_reg == 6'h20) [*7]
		|-> !serial_out_first_oe; endproperty
	a_ext: assert property (p_ext) else $error("line driven past 32");
	property p_track; $fell(hold_active) && !frame_sel_n
		&& power_state == 3'h1 |-> rise_cnt_reg == 6'h0D; endproperty
	a_track: assert property (p_track) else $error("track at wrong edge");
	property p_wake; $fell(hold_active) && !frame_sel_n
		&& power_state != 3'h1 |-> fall_cnt_reg == 6'h01; endproperty
	a_wake: assert property (p_wake) else $error("wake track late");
	property p_pd; s_pd_abort |-> ##[2:8] power_state == 3'h2; endproperty
	a_pd: assert property (p_pd) else $error("no partial down");
endmodule : dasr_monitor

bind dasr_top dasr_monitor u_mon (.*);

//--- verification/tb_top.sv
// self-checking bench for the dual converter serial readout
`timescale 1ns/1ns
module tb_top;
	logic        core_clk;
	logic        reset_n;
	logic [3:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        sample_valid;
	logic        sample_ready;
	logic [23:0] sample_data;
	logic        frame_sel_n;
	logic        serial_clk;
	logic        serial_out_first;
	logic        serial_out_first_oe;
	logic        serial_out_second;
	logic        serial_out_second_oe;
	logic        hold_active;
	logic [2:0]  power_state;
	int          err_total;
	int          checks_done;
	int          cycles;

	dasr_top #(.FIFO_DEPTH(16)) uut (.*);
	dasr_host_model host (.*);

	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [11:0] res_a(input int i);
		res_a = {4'hA, i[3:0], 4'h5};
	endfunction : res_a
	function automatic logic [11:0] res_b(input int i);
		res_b = {4'h3, ~i[3:0], 4'hC};
	endfunction : res_b
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude
	task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= 1'b1;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask : bus_write
	task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_read    <= 1'b1;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask : bus_read

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic test_regs;
		logic [31:0] d;
		bus_read(4'h4, d);
		check("status reset", d, 32'h0000_0004);
		bus_write(4'h2, 32'hFFFF_FFFF);
		bus_read(4'h2, d);
		check("unmapped", d, 32'h0000_0000);
		bus_read(4'h0, d);
		check("ctrl after stray write", d, 32'h0000_0000);
		bus_write(4'h0, 32'h0000_0003);
		bus_read(4'h0, d);
		check("ctrl back", d, 32'h0000_0003);
		avs_byteenable <= 4'hE;
		bus_write(4'h0, 32'h0000_0000);
		avs_byteenable <= 4'hF;
		bus_read(4'h0, d);
		check("ctrl lane off", d, 32'h0000_0003);
		$display("test regs done");
	endtask : test_regs
	task automatic test_fill;
		int          n;
		logic [31:0] d;
		n = 0;
		@(posedge core_clk);
		sample_valid <= 1'b1;
		sample_data  <= {res_a(0), res_b(0)};
		while (n < 20)
		begin
			@(posedge core_clk);
			if (sample_ready !== 1'b1)
				break;
			n++;
			sample_data <= {res_a(n), res_b(n)};
		end
		sample_valid <= 1'b0;
		check("fifo accepted", 32'(n), 32'h0000_0010);
		bus_read(4'h4, d);
		check("fifo level", {27'h0, d[20:16]}, 32'h0000_0010);
		$display("test fill done");
	endtask : test_fill
	task automatic test_drain;
		logic [15:0] wa;
		logic [15:0] wb;
		logic [31:0] d;
		for (int i = 0; i < 16; i++)
		begin
			bus_write(4'h0, {30'h0, i[1:0]});
			host.run_frame(i == 0 ? 32 : 16);
			wa = {1'b0, i[0], i[1], 1'b0, res_a(i)};
			wb = {1'b0, i[0], i[1], 1'b1, res_b(i)};
			check("line first", host.cap_first,
				i == 0 ? {wa, wb} : {16'h0, wa});
			check("line second", host.cap_second,
				i == 0 ? {wb, wa} : {16'h0, wb});
			bus_read(4'h8, d);
			check("last word a", d, {16'h0, wa});
		end
		$display("test drain done");
	endtask : test_drain
	task automatic test_empty;
		logic [31:0] d;
		host.run_frame(16);
		check("empty first", host.cap_first, 32'h0000_6000);
		check("empty second", host.cap_second, 32'h0000_7000);
		bus_read(4'h4, d);
		check("status flags", d & 32'h001F_3F20, 32'h0000_1020);
		bus_write(4'h4, 32'h0000_0020);
		bus_read(4'h4, d);
		check("sticky cleared", d & 32'h0000_0020, 32'h0000_0000);
		$display("test empty done");
	endtask : test_empty
	task automatic test_power;
		int          falls[6] = '{1, 2, 10, 2, 9, 10};
		logic [2:0]  mode[6]  = '{3'h1, 3'h2, 3'h1, 3'h2, 3'h4, 3'h1};
		logic [31:0] d;
		for (int i = 0; i < 6; i++)
		begin
			host.run_frame(falls[i]);
			check("power pins", {29'h0, power_state}, {29'h0, mode[i]});
			bus_read(4'h4, d);
			check("power status", {29'h0, d[4:2]}, {29'h0, mode[i]});
		end
		$display("test power done");
	endtask : test_power

	// ****************************************************************
	// main sequence and hang guard
	// ****************************************************************
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 10000)
		begin
			err_total++;
			$display("[FAIL] run time expected end seen hang");
			conclude();
		end
	end
	initial
	begin
		reset_n        = 1'b0;
		avs_address    = 4'h0;
		avs_read       = 1'b0;
		avs_write      = 1'b0;
		avs_writedata  = 32'h0000_0000;
		avs_byteenable = 4'hF;
		sample_valid   = 1'b0;
		sample_data    = 24'h00_0000;
		err_total      = 0;
		checks_done    = 0;
		cycles         = 0;
		repeat (6) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		test_regs();
		test_fill();
		test_drain();
		test_empty();
		test_power();
		conclude();
	end
endmodule : tb_top
